// ### iod_io_space_access_decoder.sv
// iod_io_space_access_decoder: i/o register space and its access decode
// assumes the core issues at most one request per clock on the same clock
// Functional notes
// - single-bit set and clear work only on i/o addresses 0 to 0x1F.
// - single-bit tests work on i/o addresses 0 to 0x1F.
// - flag bits clear on a written one and keep on a written zero.
// - bit set and clear rewrite the whole register, so set flags clear, except the bit that a clear addresses.
// - i/o read and write instructions reach only i/o addresses 0 to 63.
// - data load and store reach i/o registers at i/o address plus 0x20.
// - the extended range 0x60 to 0xFF is reached by load and store only.
// - sleep takes one clock, changes no flags and requests low power.
// - watchdog restart takes one clock, changes no flags, restarts it.
// - break acts only when on-chip debug is enabled.
module iod_io_space_access_decoder
    import iod_pkg::*;
#(
    parameter int EXT_DEPTH = 160
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // core request and answer
    input wire logic req_valid_in,
    input wire iod_req_t req_in,
    output logic done_out,
    output logic hit_out,
    output logic skip_out,
    output logic [7:0] rdata_out,
    // system control
    input wire logic debug_en_in,
    output logic sleep_req_out,
    output logic wdt_restart_out,
    output logic break_out,
    // port pins
    input wire logic [3:0][7:0] pin_in,
    output logic [3:0][7:0] pin_out,
    output logic [3:0][7:0] pin_oe_out,
    // peripherals
    input wire iod_events_t events_in,
    input wire logic comparator_in,
    output logic [1:0] timer0_force_out
);

    logic [7:0] io_mem [64];
    logic [7:0] next_io_mem [64];
    logic [7:0] ext_mem [EXT_DEPTH];
    logic [3:0][7:0] pin_meta;
    logic [3:0][7:0] pin_sync;
    logic cmp_meta;
    logic cmp_sync;
    logic io_hit;
    logic ext_hit;
    logic io_we;
    logic ext_we;
    logic [5:0] idx;
    logic [7:0] eidx;
    logic [7:0] cur_rd;
    logic [7:0] ext_rd;
    logic [7:0] wd;
    logic [7:0] bit_one;
    logic is_read;
    logic is_skip;

    // event bits that belong to an i/o address
    function automatic logic [7:0] ev_for(input logic [5:0] a,
                                          input iod_events_t e);
        case (a)
            IOD_A_TIMER0_FLAGS: return e.timer0;
            IOD_A_TIMER1_FLAGS: return e.timer1;
            IOD_A_TIMER2_FLAGS: return e.timer2;
            IOD_A_TIMER3_FLAGS: return e.timer3;
            IOD_A_PIN_CHANGE_FLAGS: return e.pin_change;
            IOD_A_EXTERNAL_IRQ_FLAGS: return e.external_irq;
            IOD_A_SERIAL_PERIPH_STATUS: return e.serial_periph;
            IOD_A_COMPARATOR_CONTROL_STATUS: return e.comparator;
            default: return 8'h00;
        endcase
    endfunction

    // pins and comparator level through two flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
        end
    end

    // address decode
    always_comb begin
        io_hit = 1'b0;
        ext_hit = 1'b0;
        idx = req_in.addr[5:0];
        eidx = 8'h00;
        if (req_valid_in) begin
            case (req_in.op)
                IOD_IO_READ_OP, IOD_IO_WRITE_OP: begin
                    io_hit = (req_in.addr < IOD_IO_SPAN);
                end
                IOD_SET_IO_BIT_OP, IOD_CLEAR_IO_BIT_OP,
                IOD_SKIP_IF_IO_BIT_ONE, IOD_SKIP_IF_IO_BIT_ZERO: begin
                    io_hit = (req_in.addr <= IOD_BIT_LAST);
                end
                IOD_DATA_LOAD_OP, IOD_DATA_STORE_OP: begin
                    if (req_in.addr >= IOD_DATA_OFS &&
                        req_in.addr < IOD_EXT_FIRST) begin
                        io_hit = 1'b1;
                        idx = 6'(req_in.addr - IOD_DATA_OFS);
                    end else if (req_in.addr >= IOD_EXT_FIRST &&
                                 req_in.addr <= IOD_EXT_LAST &&
                                 32'(req_in.addr - IOD_EXT_FIRST)
                                 < EXT_DEPTH) begin
                        ext_hit = 1'b1;
                        eidx = 8'(req_in.addr - IOD_EXT_FIRST);
                    end
                end
                default: begin
                    io_hit = 1'b0;
                end
            endcase
        end
    end

    // read view of the addressed register
    always_comb begin
        case (idx)
            IOD_A_PORT_A_PIN_INPUT: cur_rd = pin_sync[0];
            IOD_A_PORT_B_PIN_INPUT: cur_rd = pin_sync[1];
            IOD_A_PORT_C_PIN_INPUT: cur_rd = pin_sync[2];
            IOD_A_PORT_D_PIN_INPUT: cur_rd = pin_sync[3];
            IOD_A_COMPARATOR_CONTROL_STATUS: begin
                cur_rd = io_mem[idx] & (iod_rw_mask(idx) | iod_w1c_mask(idx));
                cur_rd[IOD_CMP_POS] = cmp_sync;
            end
            default: begin
                cur_rd = io_mem[idx]
                       & (iod_rw_mask(idx) | iod_w1c_mask(idx));
            end
        endcase
        ext_rd = ext_mem[eidx];
    end

    // write value, with bit ops as read-modify-write
    always_comb begin
        bit_one = 8'h01 << req_in.bit_sel;
        wd = req_in.wdata;
        io_we = 1'b0;
        is_read = 1'b0;
        is_skip = 1'b0;
        case (req_in.op)
            IOD_IO_WRITE_OP, IOD_DATA_STORE_OP: io_we = io_hit;
            IOD_SET_IO_BIT_OP: begin
                wd = cur_rd | bit_one;
                io_we = io_hit;
            end
            IOD_CLEAR_IO_BIT_OP: begin
                wd = cur_rd & ~bit_one;
                io_we = io_hit;
            end
            IOD_IO_READ_OP, IOD_DATA_LOAD_OP: is_read = 1'b1;
            IOD_SKIP_IF_IO_BIT_ONE, IOD_SKIP_IF_IO_BIT_ZERO: is_skip = 1'b1;
            default: is_read = 1'b0;
        endcase
        ext_we = ext_hit && (req_in.op == IOD_DATA_STORE_OP);
    end

    // register next values; a hardware set wins over a clear
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            next_io_mem[i] = io_mem[i];
            if (io_we && idx == 6'(i)) begin
                next_io_mem[i] = (io_mem[i] & ~iod_rw_mask(6'(i)))
                               | (wd & iod_rw_mask(6'(i)));
                next_io_mem[i] = next_io_mem[i]
                               & ~(wd & iod_w1c_mask(6'(i)));
            end
            next_io_mem[i] = next_io_mem[i]
                           | (ev_for(6'(i), events_in) & iod_w1c_mask(6'(i)));
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < 64; i++) begin
                io_mem[i] <= IOD_RESET;
            end
        end else begin
            for (int i = 0; i < 64; i++) begin
                io_mem[i] <= next_io_mem[i];
            end
        end
    end

    // extended range storage
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < EXT_DEPTH; i++) begin
                ext_mem[i] <= IOD_RESET;
            end
        end else if (ext_we) begin
            ext_mem[eidx] <= req_in.wdata;
        end
    end

    // answer to the core, one clock after the request
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_out <= 1'b0;
            hit_out <= 1'b0;
            skip_out <= 1'b0;
            rdata_out <= 8'h00;
        end else begin
            done_out <= req_valid_in;
            hit_out <= io_hit || ext_hit;
            skip_out <= 1'b0;
            rdata_out <= 8'h00;
            if (io_hit && is_skip) begin
                skip_out <= cur_rd[req_in.bit_sel]
                    ^ (req_in.op == IOD_SKIP_IF_IO_BIT_ZERO);
            end
            if (is_read && io_hit) begin
                rdata_out <= cur_rd;
            end else if (is_read && ext_hit) begin
                rdata_out <= ext_rd;
            end
        end
    end

    // one-clock system strobes
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sleep_req_out <= 1'b0;
            wdt_restart_out <= 1'b0;
            break_out <= 1'b0;
        end else begin
            sleep_req_out <= req_valid_in
                && req_in.op == IOD_SLEEP_OP;
            wdt_restart_out <= req_valid_in
                && req_in.op == IOD_WATCHDOG_RESTART_OP;
            break_out <= req_valid_in && debug_en_in
                && req_in.op == IOD_BREAK_OP;
        end
    end

    // timer0 force strobes, never stored
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            timer0_force_out <= 2'b00;
        end else if (io_we && idx == IOD_A_TIMER0_CONTROL_B) begin
            timer0_force_out <= wd[IOD_FORCE_POS +: 2];
        end else begin
            timer0_force_out <= 2'b00;
        end
    end

    // port pins straight from register flops
    always_comb begin
        pin_out[0] = io_mem[IOD_A_PORT_A_OUTPUT];
        pin_out[1] = io_mem[IOD_A_PORT_B_OUTPUT];
        pin_out[2] = io_mem[IOD_A_PORT_C_OUTPUT];
        pin_out[3] = io_mem[IOD_A_PORT_D_OUTPUT];
        pin_oe_out[0] = io_mem[IOD_A_PORT_A_DIRECTION];
        pin_oe_out[1] = io_mem[IOD_A_PORT_B_DIRECTION];
        pin_oe_out[2] = io_mem[IOD_A_PORT_C_DIRECTION];
        pin_oe_out[3] = io_mem[IOD_A_PORT_D_DIRECTION];
    end

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_bit_op_high;
        req_valid_in && req_in.addr > IOD_BIT_LAST &&
        (req_in.op == IOD_SET_IO_BIT_OP || req_in.op == IOD_CLEAR_IO_BIT_OP);
    endsequence

    sequence s_flag_set_op;
        req_valid_in && req_in.op == IOD_SET_IO_BIT_OP &&
        req_in.addr == 16'(IOD_A_TIMER0_FLAGS) && events_in.timer0 == 8'h00;
    endsequence

    chk_bit_op_range: assert property (
        s_bit_op_high |=> done_out && !hit_out &&
        $stable(io_mem[IOD_A_TIMER0_CONTROL_A]))
        else $error("bit op above 0x1F was taken");

    chk_bit_test_value: assert property (
        req_valid_in && io_hit && req_in.op == IOD_SKIP_IF_IO_BIT_ONE
        |=> skip_out == $past(cur_rd[req_in.bit_sel]))
        else $error("bit test answer wrong");

    chk_flag_one_clears: assert property (
        req_valid_in && req_in.op == IOD_IO_WRITE_OP &&
        req_in.addr == 16'(IOD_A_TIMER0_FLAGS) && req_in.wdata[1] &&
        !events_in.timer0[1] |=> !io_mem[IOD_A_TIMER0_FLAGS][1])
        else $error("flag not cleared by one");

    chk_flag_zero_keeps: assert property (
        req_valid_in && req_in.op == IOD_IO_WRITE_OP &&
        req_in.addr == 16'(IOD_A_TIMER0_FLAGS) && !req_in.wdata[0] &&
        io_mem[IOD_A_TIMER0_FLAGS][0] |=> io_mem[IOD_A_TIMER0_FLAGS][0])
        else $error("flag lost on zero write");

    chk_rmw_clears_flags: assert property (
        s_flag_set_op ##0 (io_mem[IOD_A_TIMER0_FLAGS] != 8'h00)
        |=> (io_mem[IOD_A_TIMER0_FLAGS] & 8'h07) == 8'h00)
        else $error("bit set did not clear set flags");

    chk_io_span: assert property (
        req_valid_in && req_in.op == IOD_IO_READ_OP &&
        req_in.addr >= IOD_IO_SPAN |=> !hit_out && rdata_out == 8'h00)
        else $error("i/o read beyond 63 answered");

    chk_data_mirror: assert property (
        req_valid_in && req_in.op == IOD_DATA_STORE_OP &&
        req_in.addr == IOD_DATA_OFS + 16'(IOD_A_PORT_A_OUTPUT)
        |=> hit_out && pin_out[0] == $past(req_in.wdata))
        else $error("data store did not mirror i/o register");

    chk_ext_data_only: assert property (
        req_valid_in && req_in.op == IOD_IO_WRITE_OP &&
        req_in.addr >= IOD_EXT_FIRST |=> !hit_out)
        else $error("i/o write reached extended range");

    chk_sleep_strobe: assert property (
        req_valid_in && req_in.op == IOD_SLEEP_OP && events_in == '0
        |=> sleep_req_out && $stable(io_mem[IOD_A_TIMER0_FLAGS])
        ##1 !sleep_req_out
            || $past(req_valid_in && req_in.op == IOD_SLEEP_OP))
        else $error("sleep strobe wrong");

    chk_wdt_strobe: assert property (
        req_valid_in && req_in.op == IOD_WATCHDOG_RESTART_OP
        |=> wdt_restart_out && done_out)
        else $error("watchdog restart not one clock");

    chk_break_gate: assert property (
        break_out |-> $past(req_valid_in) && $past(debug_en_in)
        && $past(req_in.op) == IOD_BREAK_OP)
        else $error("break without debug enable");

    chk_reserved_zero: assert property (
        req_valid_in && req_in.op == IOD_IO_READ_OP &&
        req_in.addr == 16'h000C |=> hit_out && rdata_out == 8'h00)
        else $error("reserved location not zero");

    chk_clear_rmw_flags: assert property (
        req_valid_in && req_in.op == IOD_CLEAR_IO_BIT_OP &&
        req_in.addr == 16'(IOD_A_TIMER1_FLAGS) && events_in.timer1 == 8'h00
        |=> (io_mem[IOD_A_TIMER1_FLAGS]
             & ~(8'h01 << $past(req_in.bit_sel))) == 8'h00)
        else $error("bit clear kept other set flags");

    chk_ext_store_hit: assert property (
        req_valid_in && req_in.op == IOD_DATA_STORE_OP &&
        req_in.addr >= IOD_EXT_FIRST && req_in.addr <= IOD_EXT_LAST &&
        32'(req_in.addr - IOD_EXT_FIRST) < EXT_DEPTH
        |=> done_out && hit_out)
        else $error("data store to extended range refused");

    chk_wdt_flags_keep: assert property (
        req_valid_in && req_in.op == IOD_WATCHDOG_RESTART_OP &&
        events_in == '0 |=> $stable(io_mem[IOD_A_TIMER0_FLAGS]))
        else $error("watchdog restart changed a flag");

    chk_write_only_bits: assert property (
        req_valid_in && req_in.op == IOD_IO_WRITE_OP &&
        req_in.addr == 16'(IOD_A_TIMER0_CONTROL_B)
        |=> (io_mem[IOD_A_TIMER0_CONTROL_B] & 8'hF0) == 8'h00)
        else $error("write-only or reserved bits were stored");

endmodule

// ### iod_pkg.sv
// iod_pkg: constants, masks and types of the i/o register space decoder
// assumes one processor clock and one asynchronous reset for all users
package iod_pkg;

    localparam logic [15:0] IOD_IO_SPAN = 16'h0040;
    localparam logic [15:0] IOD_BIT_LAST = 16'h001F;
    localparam logic [15:0] IOD_DATA_OFS = 16'h0020;
    localparam logic [15:0] IOD_EXT_FIRST = 16'h0060;
    localparam logic [15:0] IOD_EXT_LAST = 16'h00FF;
    localparam logic [7:0] IOD_RESET = 8'h00;
    localparam logic [7:0] IOD_FORCE_MASK = 8'hC0;
    localparam int IOD_FORCE_POS = 6;
    localparam int IOD_CMP_POS = 5;

    // i/o addresses
    localparam logic [5:0] IOD_A_PORT_A_PIN_INPUT = 6'h00;
    localparam logic [5:0] IOD_A_PORT_A_DIRECTION = 6'h01;
    localparam logic [5:0] IOD_A_PORT_A_OUTPUT = 6'h02;
    localparam logic [5:0] IOD_A_PORT_B_PIN_INPUT = 6'h03;
    localparam logic [5:0] IOD_A_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] IOD_A_PORT_B_OUTPUT = 6'h05;
    localparam logic [5:0] IOD_A_PORT_C_PIN_INPUT = 6'h06;
    localparam logic [5:0] IOD_A_PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] IOD_A_PORT_C_OUTPUT = 6'h08;
    localparam logic [5:0] IOD_A_PORT_D_PIN_INPUT = 6'h09;
    localparam logic [5:0] IOD_A_PORT_D_DIRECTION = 6'h0A;
    localparam logic [5:0] IOD_A_PORT_D_OUTPUT = 6'h0B;
    localparam logic [5:0] IOD_A_TIMER0_FLAGS = 6'h15;
    localparam logic [5:0] IOD_A_TIMER1_FLAGS = 6'h16;
    localparam logic [5:0] IOD_A_TIMER2_FLAGS = 6'h17;
    localparam logic [5:0] IOD_A_TIMER3_FLAGS = 6'h18;
    localparam logic [5:0] IOD_A_PIN_CHANGE_FLAGS = 6'h1B;
    localparam logic [5:0] IOD_A_EXTERNAL_IRQ_FLAGS = 6'h1C;
    localparam logic [5:0] IOD_A_EXTERNAL_IRQ_MASK = 6'h1D;
    localparam logic [5:0] IOD_A_GENERAL_SCRATCH_0 = 6'h1E;
    localparam logic [5:0] IOD_A_TIMER0_CONTROL_A = 6'h24;
    localparam logic [5:0] IOD_A_TIMER0_CONTROL_B = 6'h25;
    localparam logic [5:0] IOD_A_TIMER0_COUNT = 6'h26;
    localparam logic [5:0] IOD_A_TIMER0_COMPARE_A = 6'h27;
    localparam logic [5:0] IOD_A_TIMER0_COMPARE_B = 6'h28;
    localparam logic [5:0] IOD_A_GENERAL_SCRATCH_1 = 6'h2A;
    localparam logic [5:0] IOD_A_GENERAL_SCRATCH_2 = 6'h2B;
    localparam logic [5:0] IOD_A_SERIAL_PERIPH_CONTROL = 6'h2C;
    localparam logic [5:0] IOD_A_SERIAL_PERIPH_STATUS = 6'h2D;
    localparam logic [5:0] IOD_A_SERIAL_PERIPH_DATA = 6'h2E;
    localparam logic [5:0] IOD_A_COMPARATOR_CONTROL_STATUS = 6'h30;
    localparam logic [5:0] IOD_A_DEBUG_CHANNEL = 6'h31;

    typedef enum logic [3:0] {
        IOD_IDLE_OP, IOD_IO_READ_OP, IOD_IO_WRITE_OP, IOD_SET_IO_BIT_OP,
        IOD_CLEAR_IO_BIT_OP, IOD_SKIP_IF_IO_BIT_ONE, IOD_SKIP_IF_IO_BIT_ZERO,
        IOD_DATA_LOAD_OP, IOD_DATA_STORE_OP, IOD_SLEEP_OP,
        IOD_WATCHDOG_RESTART_OP, IOD_BREAK_OP
    } iod_op_t;

    typedef struct packed {
        iod_op_t op;
        logic [15:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } iod_req_t;

    typedef struct packed {
        logic [7:0] timer0;
        logic [7:0] timer1;
        logic [7:0] timer2;
        logic [7:0] timer3;
        logic [7:0] pin_change;
        logic [7:0] external_irq;
        logic [7:0] serial_periph;
        logic [7:0] comparator;
    } iod_events_t;

    // bits that store what software writes
    function automatic logic [7:0] iod_rw_mask(input logic [5:0] a);
        case (a)
            IOD_A_PORT_A_DIRECTION, IOD_A_PORT_A_OUTPUT,
            IOD_A_PORT_B_DIRECTION, IOD_A_PORT_B_OUTPUT,
            IOD_A_PORT_C_DIRECTION, IOD_A_PORT_C_OUTPUT,
            IOD_A_PORT_D_DIRECTION, IOD_A_PORT_D_OUTPUT,
            IOD_A_GENERAL_SCRATCH_0, IOD_A_TIMER0_COUNT,
            IOD_A_TIMER0_COMPARE_A, IOD_A_TIMER0_COMPARE_B,
            IOD_A_GENERAL_SCRATCH_1, IOD_A_GENERAL_SCRATCH_2,
            IOD_A_SERIAL_PERIPH_CONTROL, IOD_A_SERIAL_PERIPH_DATA,
            IOD_A_DEBUG_CHANNEL: return 8'hFF;
            IOD_A_EXTERNAL_IRQ_MASK: return 8'h07;
            IOD_A_TIMER0_CONTROL_A: return 8'hF3;
            IOD_A_TIMER0_CONTROL_B: return 8'h0F;
            IOD_A_SERIAL_PERIPH_STATUS: return 8'h01;
            IOD_A_COMPARATOR_CONTROL_STATUS: return 8'hCF;
            default: return 8'h00;
        endcase
    endfunction

    // flag bits: set by hardware, cleared by writing one
    function automatic logic [7:0] iod_w1c_mask(input logic [5:0] a);
        case (a)
            IOD_A_TIMER0_FLAGS, IOD_A_TIMER2_FLAGS: return 8'h07;
            IOD_A_TIMER1_FLAGS, IOD_A_TIMER3_FLAGS: return 8'h27;
            IOD_A_PIN_CHANGE_FLAGS: return 8'h0F;
            IOD_A_EXTERNAL_IRQ_FLAGS: return 8'h07;
            IOD_A_SERIAL_PERIPH_STATUS: return 8'hC0;
            IOD_A_COMPARATOR_CONTROL_STATUS: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction

endpackage

// ### iod_core_model.sv
// iod_core_model: behavioural core issuing i/o and data requests
// assumes requests are taken on the rising edge of clk_in
module iod_core_model
    import iod_pkg::*;
(
    // clock
    input wire logic clk_in,
    // request
    output logic req_valid_out,
    output iod_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid_out = 1'b0;
        req_out = '0;
    end

    // one request per edge, back to back allowed
    // callers keep reserved bits zero
    // and never write reserved locations
    task automatic issue(input iod_op_t op, input logic [15:0] a,
            input logic [2:0] b, input logic [7:0] d);
        @(posedge clk_in);
        req_valid_out <= 1'b1;
        req_out <= '{op: op, addr: a, bit_sel: b, wdata: d};
    endtask

    // released bus: payload flips so stale data never looks valid
    task automatic idle();
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        req_out.addr <= ~req_out.addr;
        req_out.wdata <= ~req_out.wdata;
    endtask
endmodule

// ### test_io_space_access_decoder.sv
// test_io_space_access_decoder: self-checking bench of the decoder
// assumes iod_core_model drives the request side
module test_io_space_access_decoder
    import iod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [14:0] HIT = 15'h4000;
    localparam logic [14:0] MISS = 15'h0000;
    localparam logic [14:0] SKIP = 15'h6000;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic req_valid_in;
    iod_req_t req_in;
    logic done_out, hit_out, skip_out;
    logic [7:0] rdata_out, v, w;
    logic debug_en_in = 1'b0;
    logic sleep_req_out, wdt_restart_out, break_out;
    logic [3:0][7:0] pin_in = '0;
    logic [3:0][7:0] pin_out, pin_oe_out;
    iod_events_t events_in = '0;
    logic comparator_in = 1'b0;
    logic [1:0] timer0_force_out;
    wire logic [14:0] got;
    int errors = 0;
    int cmp_count = 0;
    int unsigned seed_val;
    logic [14:0] notes[$];
    logic [7:0] shadow[64];
    logic [5:0] ta[21] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h07, 6'h08,
        6'h0A, 6'h0B, 6'h1D, 6'h1E, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28,
        6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h31};
    logic [7:0] tm[21] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hF3, 8'h0F, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF};

    assign got = {hit_out, skip_out, rdata_out, sleep_req_out,
        wdt_restart_out, break_out, timer0_force_out};
    always #12.5 clk_in = ~clk_in;

    iod_core_model iod_core_model_inst (
        .clk_in(clk_in),
        .req_valid_out(req_valid_in),
        .req_out(req_in)
    );

    iod_io_space_access_decoder #(.EXT_DEPTH(160))
            iod_io_space_access_decoder_inst (
        .clk_in, .arst_n_in, .req_valid_in, .req_in, .done_out, .hit_out,
        .skip_out, .rdata_out, .debug_en_in, .sleep_req_out,
        .wdt_restart_out, .break_out, .pin_in, .pin_out, .pin_oe_out,
        .events_in, .comparator_in, .timer0_force_out
    );

    task automatic check_val(input logic [14:0] e, input logic [14:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // note the expected answer, then hand the request to the core
    task automatic rq(input iod_op_t op, input logic [15:0] a,
            input logic [2:0] b, input logic [7:0] d, input logic [14:0] e);
        notes.push_back(e);
        iod_core_model_inst.issue(op, a, b, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        rq(IOD_IO_READ_OP, a, 3'h0, 8'h00, {2'b10, x, 5'h00});
    endtask

    task automatic drain(input string name);
        iod_core_model_inst.idle();
        repeat (3) @(posedge clk_in);
        check_val(15'h0000, 15'(notes.size()));
        $display("test %s done", name);
    endtask

    // answer watcher: oldest note against each done cycle
    always @(negedge clk_in) begin
        if (done_out === 1'b1) begin
            if (notes.size() == 0)
                check_val(15'h7FFF, got); // no answer was due
            else
                check_val(notes.pop_front(), got);
        end
    end

    initial begin
        #50us;
        errors++;
        tally_and_finish();
    end

    initial begin
        seed_val = $urandom(32'h0c79_724e);
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        // reset value, write through one path, read through the other
        for (int i = 0; i < 21; i++) begin
            v = 8'($urandom()) & tm[i];
            shadow[ta[i]] = v;
            rd(16'(ta[i]), 8'h00);
            if (i % 2)
                rq(IOD_DATA_STORE_OP, 16'(ta[i]) + IOD_DATA_OFS, 3'h0, v,
                    HIT);
            else
                rq(IOD_IO_WRITE_OP, 16'(ta[i]), 3'h0, v, HIT);
        end
        for (int i = 0; i < 21; i++) begin
            if (i % 2)
                rd(16'(ta[i]), shadow[ta[i]]);
            else
                rq(IOD_DATA_LOAD_OP, 16'(ta[i]) + IOD_DATA_OFS, 3'h0, 8'h00,
                    {2'b10, shadow[ta[i]], 5'h00});
        end
        drain("registers");
        for (int k = 0; k < 4; k++) begin
            check_val({7'h00, shadow[2 + 3 * k]}, {7'h00, pin_out[k]});
            check_val({7'h00, shadow[1 + 3 * k]}, {7'h00, pin_oe_out[k]});
        end
        // ranges, extended space and reserved places
        v = 8'($urandom());
        w = 8'($urandom());
        rq(IOD_IO_READ_OP, 16'h0040, 3'h0, 8'h00, MISS);
        rq(IOD_DATA_STORE_OP, 16'h0060, 3'h0, v, HIT);
        rq(IOD_DATA_STORE_OP, 16'h00FF, 3'h0, w, HIT);
        rq(IOD_IO_WRITE_OP, 16'h0060, 3'h0, 8'h5A, MISS);
        rq(IOD_DATA_LOAD_OP, 16'h0060, 3'h0, 8'h00, {2'b10, v, 5'h00});
        rq(IOD_DATA_LOAD_OP, 16'h00FF, 3'h0, 8'h00, {2'b10, w, 5'h00});
        rq(IOD_DATA_LOAD_OP, 16'h0100, 3'h0, 8'h00, MISS);
        rq(IOD_DATA_LOAD_OP, 16'h001F, 3'h0, 8'h00, MISS);
        rd(16'h000C, 8'h00);
        rd(16'h0029, 8'h00);
        rd(16'h003C, 8'h00);
        drain("ranges");
        // single-bit set, clear and test
        shadow[5] = shadow[5] | 8'h08;
        rq(IOD_SET_IO_BIT_OP, 16'h0005, 3'h3, 8'h00, HIT);
        rq(IOD_SKIP_IF_IO_BIT_ONE, 16'h0005, 3'h3, 8'h00, SKIP);
        rq(IOD_SKIP_IF_IO_BIT_ZERO, 16'h0005, 3'h3, 8'h00, HIT);
        rq(IOD_CLEAR_IO_BIT_OP, 16'h0005, 3'h3, 8'h00, HIT);
        rq(IOD_SKIP_IF_IO_BIT_ZERO, 16'h0005, 3'h3, 8'h00, SKIP);
        rd(16'h0005, shadow[5] & 8'hF7);
        rq(IOD_SET_IO_BIT_OP, 16'h0024, 3'h0, 8'h00, MISS);
        rq(IOD_SKIP_IF_IO_BIT_ONE, 16'h0020, 3'h0, 8'h00, MISS);
        rd(16'h0024, shadow[6'h24]);
        drain("bits");
        // flags, control instructions and strobes
        @(posedge clk_in);
        events_in <= {8'h07, 8'h27, 48'h0};
        @(posedge clk_in);
        events_in <= '0;
        rd(16'h0015, 8'h07);
        rq(IOD_IO_WRITE_OP, 16'h0015, 3'h0, 8'h02, HIT);
        rd(16'h0015, 8'h05);
        rq(IOD_SLEEP_OP, 16'h0000, 3'h0, 8'h00, 15'h0010);
        rq(IOD_WATCHDOG_RESTART_OP, 16'h0000, 3'h0, 8'h00, 15'h0008);
        debug_en_in <= 1'b0;
        rq(IOD_BREAK_OP, 16'h0000, 3'h0, 8'h00, MISS);
        iod_core_model_inst.idle();
        debug_en_in <= 1'b1;
        rq(IOD_BREAK_OP, 16'h0000, 3'h0, 8'h00, 15'h0004);
        rd(16'h0015, 8'h05);
        rq(IOD_SET_IO_BIT_OP, 16'h0015, 3'h1, 8'h00, HIT);
        rd(16'h0015, 8'h00);
        rq(IOD_CLEAR_IO_BIT_OP, 16'h0016, 3'h0, 8'h00, HIT);
        rd(16'h0016, 8'h01);
        rq(IOD_IO_WRITE_OP, 16'h0025, 3'h0, 8'hC5, 15'h4003);
        rd(16'h0025, 8'h05);
        drain("flags");
        // synchronised pins and comparator level
        pin_in <= $urandom();
        comparator_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        for (int k = 0; k < 4; k++)
            rd(16'(3 * k), pin_in[k]);
        rd(16'h0030, 8'h20);
        drain("pins");
        tally_and_finish();
    end
endmodule
